// >>> bmc_pkg.sv
// bus matrix configuration: shared constants, register map and field layout
// assumes a 32-bit avalon-mm register port with word addressing
package bmc_pkg;

  localparam int unsigned N_INIT       = 5;
  localparam int unsigned ADDR_W       = 2;

  // initiator index order, also the bit order of error and interrupt vectors
  localparam int unsigned INIT_CPU_INSTR = 0;
  localparam int unsigned INIT_CPU_DATA  = 1;
  localparam int unsigned INIT_DMA       = 2;
  localparam int unsigned INIT_DEBUG     = 3;
  localparam int unsigned INIT_PERIPH    = 4;

  // word addresses
  localparam logic [1:0] ADDR_CONFIG   = 2'h0;
  localparam logic [1:0] ADDR_IRQ_STAT = 2'h1;
  localparam logic [1:0] ADDR_IRQ_MASK = 2'h2;
  localparam logic [1:0] ADDR_ACTIVE   = 2'h3;

  // bus_matrix_config fields
  localparam int unsigned ARB_LSB       = 0;
  localparam int unsigned ARB_W         = 3;
  localparam int unsigned WAIT_BIT      = 6;
  localparam int unsigned ERR_EN_LSB    = 16;
  localparam logic [31:0] CONFIG_RESET  = 32'h001f_0041;
  localparam logic [31:0] CONFIG_MASK   = 32'h001f_0047;

  localparam logic [2:0]  ARB_MODE_0    = 3'h0;
  localparam logic [2:0]  ARB_MODE_1    = 3'h1;
  localparam logic [2:0]  ARB_MODE_2    = 3'h2;

  localparam logic [4:0]  IRQ_RESET     = 5'h0_0;
  localparam logic [4:0]  MASK_RESET    = 5'h0_0;

endpackage

// >>> bmc_err_gate.sv
// bus matrix configuration: per-initiator bus error gate
// assumes start, end and unmapped strobes from matrix logic on the same clock
`timescale 1ns/10ps
module bmc_err_gate (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic err_en,
  input  wire logic suppress,
  input  wire logic txn_start,
  input  wire logic txn_end,
  input  wire logic unmapped,
  output logic      busy,
  output logic      bus_err
);

  logic busy_q;
  logic en_q;
  logic en_eff;

  // enable is frozen for the whole transaction; a start cycle uses the live bit
  assign en_eff = txn_start ? err_en : en_q;
  assign busy   = busy_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (txn_start) begin
      busy_q <= ~txn_end;
    end else if (txn_end) begin
      busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      en_q <= 1'b1;
    end else if (txn_start) begin
      en_q <= err_en;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      bus_err <= 1'b0;
    end else begin
      bus_err <= unmapped & (txn_start | busy_q) & en_eff & ~suppress;
    end
  end

endmodule

// >>> bmc_top.sv
// bus matrix configuration: register slave, error gating and mode control
// assumes matrix strobes and debug flag come from logic on clk; avalon master on clk
//
// Function
// - periph bus error enable bit 20, reset 1
// - debug unit error enable bit 19, reset 1
// - dma error enable bit 18, reset 1
// - cpu data error enable, off in debug
// - cpu fetch error enable, off in debug
// - bit 6 adds data ram setup wait
// - bits 2-0 pick arbitration mode, reset 001
// - unimplemented bits read zero, ignore writes
//
// Local design decisions: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
module bmc_top (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [bmc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic [bmc_pkg::N_INIT-1:0] txn_start,
  input  wire logic [bmc_pkg::N_INIT-1:0] txn_end,
  input  wire logic [bmc_pkg::N_INIT-1:0] txn_unmapped,
  input  wire logic                       cpu_debug_mode,
  output logic [bmc_pkg::N_INIT-1:0]      bus_err,
  output logic [2:0]                      arb_mode,
  output logic                            dram_setup_wait_state,
  output logic                            irq
);

  localparam int unsigned N = bmc_pkg::N_INIT;

  logic [31:0]  config_q;
  logic [N-1:0] irq_stat_q;
  logic [N-1:0] irq_mask_q;
  logic [2:0]   arb_mode_q;
  logic         dram_wait_q;
  logic [31:0]  readdata_q;
  logic         waitreq_q;
  logic         irq_q;

  logic [N-1:0] err_en;
  logic [N-1:0] suppress;
  logic [N-1:0] busy;
  logic [N-1:0] err_pulse;
  logic         req;
  logic         ack;
  logic         wr_ack;
  logic [31:0]  be_mask;
  logic         all_idle;
  logic         cpu_idle;

  // byte enables expanded to a bit mask; used for every writable register
  function automatic logic [31:0] be_expand(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    return (old_v & ~m) | (new_v & m);
  endfunction

  // register port: one wait cycle, then a single cycle with waitrequest low
  assign req     = avs_read | avs_write;
  assign ack     = req & ~waitreq_q;
  assign wr_ack  = avs_write & ~waitreq_q;
  assign be_mask = be_expand(avs_byteenable);

  always_ff @(posedge clk) begin
    if (rst) begin
      waitreq_q <= 1'b1;
    end else if (req & waitreq_q) begin
      waitreq_q <= 1'b0;
    end else begin
      waitreq_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_q <= 32'h0000_0000;
    end else if (avs_read & waitreq_q) begin
      case (avs_address)
        bmc_pkg::ADDR_CONFIG:   readdata_q <= config_q & bmc_pkg::CONFIG_MASK;
        bmc_pkg::ADDR_IRQ_STAT: readdata_q <= {{(32-N){1'b0}}, irq_stat_q};
        bmc_pkg::ADDR_IRQ_MASK: readdata_q <= {{(32-N){1'b0}}, irq_mask_q};
        // busy sits apart from the mode field so a read mid-transaction stays unambiguous
        bmc_pkg::ADDR_ACTIVE:   readdata_q <= {{(16-N){1'b0}}, busy, 9'h000,
                                               dram_wait_q, 3'h0, arb_mode_q};
        default:                readdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // reserved codes are software's to avoid
  always_ff @(posedge clk) begin
    if (rst) begin
      config_q <= bmc_pkg::CONFIG_RESET;
    end else if (wr_ack && avs_address == bmc_pkg::ADDR_CONFIG) begin
      config_q <= merge(config_q, avs_writedata, be_mask & bmc_pkg::CONFIG_MASK);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_mask_q <= bmc_pkg::MASK_RESET;
    end else if (wr_ack && avs_address == bmc_pkg::ADDR_IRQ_MASK) begin
      irq_mask_q <= (irq_mask_q & ~be_mask[N-1:0]) | (avs_writedata[N-1:0] & be_mask[N-1:0]);
    end
  end

  // sticky status: a new error in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_stat_q <= bmc_pkg::IRQ_RESET;
    end else if (wr_ack && avs_address == bmc_pkg::ADDR_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~(avs_writedata[N-1:0] & be_mask[N-1:0])) | err_pulse;
    end else begin
      irq_stat_q <= irq_stat_q | err_pulse;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_stat_q & irq_mask_q);
    end
  end

  assign err_en = config_q[bmc_pkg::ERR_EN_LSB +: N];

  always_comb begin
    suppress = '0;
    suppress[bmc_pkg::INIT_CPU_INSTR] = cpu_debug_mode;
    suppress[bmc_pkg::INIT_CPU_DATA]  = cpu_debug_mode;
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_init
      bmc_err_gate u_gate (
        .clk       (clk),
        .rst       (rst),
        .err_en    (err_en[g]),
        .suppress  (suppress[g]),
        .txn_start (txn_start[g]),
        .txn_end   (txn_end[g]),
        .unmapped  (txn_unmapped[g]),
        .busy      (busy[g]),
        .bus_err   (err_pulse[g])
      );
    end
  endgenerate

  assign all_idle = ~|busy & ~|txn_start;
  assign cpu_idle = ~busy[bmc_pkg::INIT_CPU_INSTR] & ~busy[bmc_pkg::INIT_CPU_DATA] &
                    ~txn_start[bmc_pkg::INIT_CPU_INSTR] & ~txn_start[bmc_pkg::INIT_CPU_DATA];

  always_ff @(posedge clk) begin
    if (rst) begin
      arb_mode_q <= bmc_pkg::ARB_MODE_1;
    end else if (all_idle) begin
      arb_mode_q <= config_q[bmc_pkg::ARB_LSB +: bmc_pkg::ARB_W];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dram_wait_q <= bmc_pkg::CONFIG_RESET[bmc_pkg::WAIT_BIT];
    end else if (cpu_idle) begin
      dram_wait_q <= config_q[bmc_pkg::WAIT_BIT];
    end
  end

  assign avs_readdata          = readdata_q;
  assign avs_waitrequest       = waitreq_q;
  assign bus_err               = err_pulse;
  assign arb_mode              = arb_mode_q;
  assign dram_setup_wait_state = dram_wait_q;
  assign irq                   = irq_q;

endmodule

// >>> bmc_checker.sv
// checker: port timing of the bus matrix configuration block
// assumes bind to bmc_top, one clock clk, sync reset rst active high
`timescale 1ns/10ps
module bmc_checker (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       avs_read,
  input wire logic       avs_waitrequest,
  input wire logic [4:0] txn_start,
  input wire logic [4:0] txn_unmapped,
  input wire logic       cpu_debug_mode,
  input wire logic [4:0] bus_err,
  input wire logic [2:0] arb_mode,
  input wire logic       dram_setup_wait_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd_taken;
    avs_read && avs_waitrequest;
  endsequence
  sequence s_fetch_dbg;
    cpu_debug_mode && txn_unmapped[0];
  endsequence
  sequence s_data_dbg;
    cpu_debug_mode && txn_unmapped[1];
  endsequence
  a_rd_answer: assert property (s_rd_taken |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("read answer not one cycle");
  a_dbg_fetch: assert property (s_fetch_dbg |=> !bus_err[0])
    else $error("fetch error in debug mode");
  a_dbg_data: assert property (s_data_dbg |=> !bus_err[1])
    else $error("data error in debug mode");
  a_err_cause_pb: assert property (bus_err[4] |-> $past(txn_unmapped[4]))
    else $error("periph bus error without cause");
  a_err_cause_du: assert property (bus_err[3] |-> $past(txn_unmapped[3]))
    else $error("debug unit error without cause");
  a_err_cause_dma: assert property (bus_err[2] |-> $past(txn_unmapped[2]))
    else $error("dma error without cause");
  a_arb_legal: assert property (arb_mode <= 3'h2)
    else $error("arbitration mode not legal");
  a_arb_quiet: assert property (!$stable(arb_mode) |-> $past(txn_start) == 5'h00)
    else $error("mode changed at transaction start");
  a_ws_quiet: assert property (!$stable(dram_setup_wait_state) |-> !$past(txn_start[0]))
    else $error("wait state changed at fetch start");
endmodule

// >>> bmc_init_model.sv
// initiator model: one-cycle matrix transactions
// assumes tasks are called from the bench on clk; unmapped only inside a txn
`timescale 1ns/10ps
module bmc_init_model (
  input wire logic   clk,
  output logic [4:0] txn_start,
  output logic [4:0] txn_end,
  output logic [4:0] txn_unmapped
);
  initial begin
    txn_start    = 5'h00;
    txn_end      = 5'h00;
    txn_unmapped = 5'h00;
  end
  // start and end share a cycle, the shortest legal transaction
  task automatic txn(input int i);
    @(posedge clk);
    txn_start    <= 5'(1 << i);
    txn_end      <= 5'(1 << i);
    txn_unmapped <= 5'(1 << i);
    @(posedge clk);
    txn_start    <= 5'h00;
    txn_end      <= 5'h00;
    txn_unmapped <= 5'h00;
  endtask
endmodule

// >>> tb_top.sv
// testbench: avalon register access and initiator traffic for bmc_top
// assumes checker and initiator model are compiled before it
`timescale 1ns/10ps
module tb_top;
  logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic        cpu_debug_mode = 1'b0, avs_waitrequest, irq, dram_setup_wait_state;
  logic [1:0]  avs_address = 2'h0;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [4:0]  txn_start, txn_end, txn_unmapped, bus_err;
  logic [2:0]  arb_mode;
  logic [31:0] exp_q[$];
  logic [4:0]  err_q[$];
  logic [3:0]  avs_byteenable = 4'hf;
  int          fail_count = 0, total_checks = 0;
  always #12.5 clk = ~clk;
  bmc_init_model i_bmc_init_model (.clk, .txn_start, .txn_end, .txn_unmapped);
  bmc_top i_bmc_top (.clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .txn_start, .txn_end,
    .txn_unmapped, .cpu_debug_mode, .bus_err, .arb_mode, .dram_setup_wait_state, .irq);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // hold the request until waitrequest is sampled low
  task automatic bus(input logic [1:0] a, input logic wr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (n >= 20) begin
      fail_count++;
      stop_test;
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0000_0000);
  endtask
  // e holds the initiators whose unmapped access must be reported
  task automatic burst(input logic [4:0] e);
    for (int i = 0; i < 5; i++) begin
      if (e[i]) err_q.push_back(5'(1 << i));
      i_bmc_init_model.txn(i);
    end
    repeat (2) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0)
      chk(avs_readdata, exp_q.pop_front());
  end
  // every error pulse must match the oldest expected report; a stray one fails
  always @(posedge clk) begin
    if (bus_err !== 5'h00) begin
      if (err_q.size() > 0)
        chk(32'(bus_err), 32'(err_q.pop_front()));
      else
        chk(32'(bus_err), 32'h0000_0000);
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    fail_count++;
    stop_test;
  end
  initial begin
    logic [31:0] r;
    r = $urandom(65773);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(2'h0, 32'h001f_0041);
    chk(32'(arb_mode), 32'h0000_0001);
    chk(32'(dram_setup_wait_state), 32'h0000_0001);
    bus(2'h2, 1'b1, 32'h0000_001f);
    for (int i = 0; i < 5; i++) begin
      err_q.push_back(5'(1 << i));
      i_bmc_init_model.txn(i);
      rd(2'h1, 32'(1 << i));
      chk(32'(irq), 32'h0000_0001);
      bus(2'h1, 1'b1, 32'(1 << i));
    end
    r = ($urandom() & ~bmc_pkg::CONFIG_MASK) | 32'h0000_0002;
    bus(2'h0, 1'b1, r);
    rd(2'h0, 32'h0000_0002);
    chk(32'(arb_mode), 32'h0000_0002);
    chk(32'(dram_setup_wait_state), 32'h0000_0000);
    burst(5'h00);
    rd(2'h1, 32'h0000_0000);
    bus(2'h0, 1'b1, 32'h001f_0040);
    cpu_debug_mode <= 1'b1;
    burst(5'h1c);
    rd(2'h1, 32'h0000_001c);
    rd(2'h3, 32'h0000_0040);
    chk(32'(arb_mode), 32'h0000_0000);
    chk(32'(dram_setup_wait_state), 32'h0000_0001);
    // only the low byte lane is written; the enables must survive
    avs_byteenable <= 4'h1;
    bus(2'h0, 1'b1, 32'hffff_ff01);
    avs_byteenable <= 4'hf;
    rd(2'h0, 32'h001f_0001);
    chk(32'(arb_mode), 32'h0000_0001);
    chk(32'(dram_setup_wait_state), 32'h0000_0000);
    bus(2'h1, 1'b1, 32'h0000_001f);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0000_0000);
    chk(32'(err_q.size()), 32'h0000_0000);
    stop_test;
  end
endmodule
bind bmc_top bmc_checker i_bmc_checker (.clk, .rst, .avs_read, .avs_waitrequest, .txn_start,
  .txn_unmapped, .cpu_debug_mode, .bus_err, .arb_mode, .dram_setup_wait_state);
